/* src/mia_defs.svh */
// How it works
// - every endpoint request and every periph_req_i line except 0 to 23, 34 and 35 is ORed into one internal core request; the four other standard sources are not.
// - that combined request also drives a pin that can interrupt a controller outside the chip.
// - the core jumps to 0003h for the combined request, 000Bh for timer-0 and 0013h for external request 1.
// - the enable register holds five source enables in bits 0 to 4, all reset to 0, with bits 5 and 6 reserved.
// - the global enable in bit 7 blocks every core interrupt while 0 and hands control to the source enables while 1.
// - a source enable of 1 lets its source interrupt the core, and 0 suppresses it.
// - a vector register names the active source and has room for 64 distinct vectors.
// - the input endpoint pending register is 8 read-only bits, bit n set when input endpoint n interrupts.
// - the output endpoint pending register is 8 read-only bits, bit n set when output endpoint n interrupts.
// - an endpoint pending bit stays set until the processor writes the vector register while it holds that endpoint's vector.
// - any write to the vector register retires the current vector and loads the next pending one, 00h if none.
// - the vector has 0 in bit 7, the group in bits 6 to 4, the source in bits 3 to 1 and 0 in bit 0; group 7 ranks highest.
`ifndef MIA_DEFS_SVH
`define MIA_DEFS_SVH
`define MIA_ADDR_ENABLE     4'h0
`define MIA_ADDR_IEP        4'h1
`define MIA_ADDR_OEP        4'h2
`define MIA_ADDR_VECTOR     4'h3
`define MIA_ADDR_SRCPEND    4'h4
`define MIA_ENABLE_RESET    8'h00
`define MIA_ENABLE_WMASK    8'h9f
`define MIA_BIT_EXT0        0
`define MIA_BIT_TIMER0      1
`define MIA_BIT_EXT1        2
`define MIA_BIT_TIMER1      3
`define MIA_BIT_SERIAL      4
`define MIA_BIT_GLOBAL      7
`define MIA_VEC_NONE        8'h00
`define MIA_VEC_CORE0       16'h0003
`define MIA_VEC_TIMER0      16'h000b
`define MIA_VEC_CORE1       16'h0013
`define MIA_VEC_TIMER1      16'h001b
`define MIA_VEC_SERIAL      16'h0023
`define MIA_GRP_OEP         4'h1
`define MIA_GRP_IEP         4'h2
`define MIA_GRP_EP0         4'h4
`define MIA_IDX_IEP0        3'h2
`define MIA_IDX_OEP0        3'h3
`endif

/* src/mia_pkg.sv */
package mia_pkg;
	// one source slot per vector code: 8 groups of 8 indexes
	typedef logic [63:0] mia_src_vec_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} mia_bus_req_t;
	typedef enum logic [1:0] {
		MIA_IDLE = 2'b01,
		MIA_HOLD = 2'b10
	} mia_vec_state_t;
endpackage : mia_pkg

/* src/mia_sync.sv */
`timescale 1ns/100ps
// two-stage synchroniser for asynchronous request pins
module mia_sync
	import mia_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} mia_sync_state_t;
	mia_sync_state_t st_r;
	mia_sync_state_t st_nxt;

	// first stage is read only by the second
	always_comb begin
		st_nxt        = st_r;
		st_nxt.meta   = async_i;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_o = st_r.stable;
endmodule : mia_sync

/* src/mia_prio.sv */
`timescale 1ns/100ps
`include "mia_defs.svh"
// hard-wired priority encoder: highest group wins, then highest index
module mia_prio
	import mia_pkg::*;
(
	input  wire logic [63:0] pend_i,
	output logic      [7:0]  vector_o
);
	function automatic logic [7:0] mia_encode(input logic [63:0] p);
		logic [7:0] v;
		v = `MIA_VEC_NONE;
		// ascending scan so the last hit is the highest priority
		for (int k = 0; k < 64; k++) begin
			if (p[k]) begin
				v = {1'b0, k[5:0], 1'b0};
			end
		end
		return v;
	endfunction : mia_encode

	// slot k stands for group k/8, index k%8: vector = k*2 with bit 0 low
	always_comb begin
		vector_o = mia_encode(pend_i);
	end
endmodule : mia_prio

/* src/mia_top.sv */
`timescale 1ns/100ps
`include "mia_defs.svh"
// interrupt aggregation between peripheral request lines and the core
module mia_top
	import mia_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic [7:0]  iep_event_i,
	input  wire logic [7:0]  oep_event_i,
	input  wire logic [63:0] periph_req_i,
	input  wire logic        timer0_req_i,
	input  wire logic        timer1_req_i,
	input  wire logic        ext1_req_i,
	input  wire logic        serial_req_i,
	output logic             combined_peripheral_request_n_o,
	output logic             offchip_irq_output_n_o,
	output logic             core_irq_o,
	output logic      [15:0] core_vector_addr_o
);
	typedef struct packed {
		logic [7:0]     enable;
		logic [7:0]     iep_pend;
		logic [7:0]     oep_pend;
		logic [63:0]    held;
		logic [7:0]     vector;
		mia_vec_state_t vstate;
		logic [7:0]     rdata;
		logic           comb_n;
		logic           offchip_n;
		logic           core_irq;
		logic [15:0]    vaddr;
	} mia_state_t;

	mia_state_t   st_r;
	mia_state_t   st_nxt;
	mia_bus_req_t bus;
	logic [7:0]   iep_sync;
	logic [7:0]   oep_sync;
	logic [7:0]   iep_prev_r;
	logic [7:0]   oep_prev_r;
	logic [63:0]  pend_all;
	logic [7:0]   next_vec;
	logic         vec_write;

	assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
	assign vec_write = bus.wr && (bus.addr == `MIA_ADDR_VECTOR);

	// endpoint events come from the usb clock side, so resynchronise them
	mia_sync #(.WIDTH(8)) u_sync_iep (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (iep_event_i),
		.sync_o     (iep_sync)
	);
	mia_sync #(.WIDTH(8)) u_sync_oep (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (oep_event_i),
		.sync_o     (oep_sync)
	);

	// edge history so a held endpoint level raises one pending event
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			iep_prev_r <= 8'h00;
			oep_prev_r <= 8'h00;
		end else begin
			iep_prev_r <= iep_sync;
			oep_prev_r <= oep_sync;
		end
	end

	// map endpoint pending bits and the other peripheral lines onto vector slots
	always_comb begin
		pend_all = periph_req_i;
		pend_all[7:0] = 8'h00; // group 0 carries no source
		for (int n = 1; n < 8; n++) begin
			pend_all[8 + n]  = st_r.oep_pend[n];
			pend_all[16 + n] = st_r.iep_pend[n];
		end
		pend_all[8]  = 1'b0;
		pend_all[16] = 1'b0;
		pend_all[32 + 2] = st_r.iep_pend[0];
		pend_all[32 + 3] = st_r.oep_pend[0];
		pend_all = pend_all & ~st_r.held;
	end

	mia_prio u_prio (
		.pend_i   (pend_all),
		.vector_o (next_vec)
	);

	// next-state logic for registers, pending bits, vector and core outputs
	always_comb begin
		logic       any_src;
		logic [7:0] en;
		logic [7:0] iep_rise;
		logic [7:0] oep_rise;
		any_src  = 1'b0;
		en       = 8'h00;
		iep_rise = iep_sync & ~iep_prev_r;
		oep_rise = oep_sync & ~oep_prev_r;
		st_nxt   = st_r;

		// only the five enables and the global bit are writable
		if (bus.wr && bus.addr == `MIA_ADDR_ENABLE) begin
			st_nxt.enable = bus.wdata & `MIA_ENABLE_WMASK;
		end

		// a vector write retires the current source and clears its pending bit
		if (vec_write && st_r.vstate == MIA_HOLD) begin
			case (st_r.vector[7:4])
				`MIA_GRP_OEP: st_nxt.oep_pend[st_r.vector[3:1]] = 1'b0;
				`MIA_GRP_IEP: st_nxt.iep_pend[st_r.vector[3:1]] = 1'b0;
				`MIA_GRP_EP0: begin
					if (st_r.vector[3:1] == `MIA_IDX_IEP0) begin
						st_nxt.iep_pend[0] = 1'b0;
					end
					if (st_r.vector[3:1] == `MIA_IDX_OEP0) begin
						st_nxt.oep_pend[0] = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// set wins over clear in the same cycle
		st_nxt.iep_pend = st_nxt.iep_pend | iep_rise;
		st_nxt.oep_pend = st_nxt.oep_pend | oep_rise;

		// vector latch: held until written, then the next pending one loads
		case (st_r.vstate)
			MIA_IDLE: begin
				// mask bits survive idle; only a dropped line releases them
				if (next_vec != `MIA_VEC_NONE) begin
					st_nxt.vector = next_vec;
					st_nxt.vstate = MIA_HOLD;
				end else begin
					st_nxt.vector = `MIA_VEC_NONE;
				end
			end
			MIA_HOLD: begin
				if (vec_write) begin
					// level peripherals stay masked until dropped, avoiding an instant repeat
					st_nxt.held = st_r.held | (64'h1 << st_r.vector[7:1]);
					st_nxt.vector = `MIA_VEC_NONE;
					st_nxt.vstate = MIA_IDLE;
				end
			end
			default: begin
				st_nxt.vstate = MIA_IDLE;
				st_nxt.vector = `MIA_VEC_NONE;
			end
		endcase
		// release mask bits whose raw line has gone away
		st_nxt.held = st_nxt.held & periph_req_i;
		if (st_r.vstate == MIA_HOLD && vec_write) begin
			st_nxt.held = st_nxt.held | (64'h1 << st_r.vector[7:1]);
		end

		// combined request follows any unmasked pending source
		any_src = (|pend_all) || (st_r.vstate == MIA_HOLD);
		st_nxt.comb_n    = ~any_src;
		st_nxt.offchip_n = ~any_src;

		// gating of the five standard sources
		en = st_r.enable & {8{st_r.enable[`MIA_BIT_GLOBAL]}};
		st_nxt.core_irq = 1'b1;
		if (en[`MIA_BIT_EXT0] && any_src) begin
			st_nxt.vaddr = `MIA_VEC_CORE0;
		end else if (en[`MIA_BIT_TIMER0] && timer0_req_i) begin
			st_nxt.vaddr = `MIA_VEC_TIMER0;
		end else if (en[`MIA_BIT_EXT1] && ext1_req_i) begin
			st_nxt.vaddr = `MIA_VEC_CORE1;
		end else if (en[`MIA_BIT_TIMER1] && timer1_req_i) begin
			st_nxt.vaddr = `MIA_VEC_TIMER1;
		end else if (en[`MIA_BIT_SERIAL] && serial_req_i) begin
			st_nxt.vaddr = `MIA_VEC_SERIAL;
		end else begin
			st_nxt.core_irq = 1'b0;
			st_nxt.vaddr    = 16'h0000;
		end

		// read data stands only in the cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				`MIA_ADDR_ENABLE:  st_nxt.rdata = st_r.enable;
				`MIA_ADDR_IEP:     st_nxt.rdata = st_r.iep_pend;
				`MIA_ADDR_OEP:     st_nxt.rdata = st_r.oep_pend;
				`MIA_ADDR_VECTOR:  st_nxt.rdata = st_r.vector;
				`MIA_ADDR_SRCPEND: st_nxt.rdata = {7'h00, any_src};
				default:           st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r           <= '0;
			st_r.enable    <= `MIA_ENABLE_RESET;
			st_r.vector    <= `MIA_VEC_NONE;
			st_r.vstate    <= MIA_IDLE;
			st_r.comb_n    <= 1'b1;
			st_r.offchip_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o                     = st_r.rdata;
	assign combined_peripheral_request_n_o = st_r.comb_n;
	assign offchip_irq_output_n_o          = st_r.offchip_n;
	assign core_irq_o                      = st_r.core_irq;
	assign core_vector_addr_o              = st_r.vaddr;
endmodule : mia_top

/* verification/mia_cpu_model.sv */
`timescale 1ns/100ps
// stand-in for the core input: a low combined request counts as pending, never an edge
module mia_cpu_model (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic irq_n_i,
	output logic      taken_o
);
	// level sampled every cycle, so a request left low keeps interrupting
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			taken_o <= 1'b0;
		else
			taken_o <= !irq_n_i;
	end
endmodule : mia_cpu_model

/* verification/mia_top_properties.sv */
`timescale 1ns/100ps
// passive watcher on the top pins with its own copy of the enable byte
module mia_check (
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic [63:0] periph_req_i,
	input wire logic        timer0_req_i,
	input wire logic        ext1_req_i,
	input wire logic        combined_peripheral_request_n_o,
	input wire logic        offchip_irq_output_n_o,
	input wire logic        core_irq_o,
	input wire logic [15:0] core_vector_addr_o
);
	logic [7:0] en_r;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// shadow enable byte; reserved bits 5 and 6 never store
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			en_r <= 8'h00;
		else if (reg_wr_i && reg_addr_i == 4'h0)
			en_r <= reg_wdata_i & 8'h9f;
	end
	a_pin_mirror: assert property (offchip_irq_output_n_o == combined_peripheral_request_n_o)
		else $error("offchip pin differs");
	a_enable_readback: assert property ($past(reg_rd_i && reg_addr_i == 4'h0) |-> reg_rdata_o == $past(en_r))
		else $error("enable readback wrong");
	a_global_gate: assert property (!$past(en_r[7]) |-> !core_irq_o)
		else $error("irq while globally off");
	a_timer0_fires: assert property ($past(en_r == 8'h82 && timer0_req_i) |-> core_irq_o)
		else $error("timer0 not passed");
	a_timer0_entry: assert property ($past(en_r == 8'h82 && timer0_req_i) |-> core_vector_addr_o == 16'h000b)
		else $error("timer0 entry wrong");
	a_ext1_entry: assert property ($past(en_r == 8'h84 && ext1_req_i) |-> core_vector_addr_o == 16'h0013)
		else $error("ext1 entry wrong");
	a_idle_entry: assert property (!core_irq_o |-> core_vector_addr_o == 16'h0000)
		else $error("entry without irq");
	a_vector_even: assert property ($past(reg_rd_i && reg_addr_i == 4'h3) |-> !reg_rdata_o[0])
		else $error("odd vector");
	a_slot_raises: assert property ($rose(periph_req_i[63]) |-> ##[1:2] !combined_peripheral_request_n_o)
		else $error("slot request not combined");
endmodule : mia_check
bind mia_top mia_check i_mia_check (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .periph_req_i, .timer0_req_i, .ext1_req_i, .combined_peripheral_request_n_o,
	.offchip_irq_output_n_o, .core_irq_o, .core_vector_addr_o);

/* verification/test_mia_top.sv */
`timescale 1ns/100ps
module test_mia_top;
	logic        core_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, taken;
	logic        timer0_req_i = 1'b0, timer1_req_i = 1'b0, ext1_req_i = 1'b0, serial_req_i = 1'b0;
	logic        combined_peripheral_request_n_o, offchip_irq_output_n_o, core_irq_o;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [7:0]  reg_wdata_i = 8'h00, iep_event_i = 8'h00, oep_event_i = 8'h00, reg_rdata_o;
	logic [15:0] core_vector_addr_o;
	logic [63:0] periph_req_i = 64'h0;
	int          num_errors = 0, tests_run = 0, cycles = 0;
	always #20 core_clk_i = ~core_clk_i;
	mia_top i_mia_top (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.iep_event_i, .oep_event_i, .periph_req_i, .timer0_req_i, .timer1_req_i, .ext1_req_i, .serial_req_i,
		.combined_peripheral_request_n_o, .offchip_irq_output_n_o, .core_irq_o, .core_vector_addr_o);
	mia_cpu_model i_mia_cpu_model (.core_clk_i, .rst_n_i, .irq_n_i(combined_peripheral_request_n_o), .taken_o(taken));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cyc(1);
		{reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
		cyc(1);
		reg_wr_i <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		cyc(1);
		{reg_rd_i, reg_addr_i} <= {1'b1, a};
		cyc(1);
		reg_rd_i <= 1'b0;
		#1;
		chk({8'h00, reg_rdata_o}, {8'h00, e});
	endtask : rd
	// any value retires; two spare cycles let the next vector load
	task automatic retire;
		wr(4'h3, 8'h5a);
		cyc(2);
	endtask : retire
	task automatic t_reset_values;
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'h3, 8'h00);
		wr(4'h1, 8'hff);
		rd(4'h1, 8'h00);
		rd(4'h7, 8'h00);
	endtask : t_reset_values
	// all four sources raised, one enable at a time, then the global gate shut
	task automatic t_core_sources;
		logic [7:0]  ens [4] = '{8'h82, 8'h84, 8'h88, 8'h90};
		logic [15:0] adr [4] = '{16'h000b, 16'h0013, 16'h001b, 16'h0023};
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h9f);
		cyc(1);
		{serial_req_i, timer1_req_i, ext1_req_i, timer0_req_i} <= 4'hf;
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, ens[i]);
			cyc(2);
			#1;
			chk({15'h0, core_irq_o}, 16'h0001);
			chk(core_vector_addr_o, adr[i]);
		end
		wr(4'h0, 8'h1f);
		cyc(2);
		#1;
		chk({15'h0, core_irq_o}, 16'h0000);
		cyc(1);
		{serial_req_i, timer1_req_i, ext1_req_i, timer0_req_i} <= 4'h0;
	endtask : t_core_sources
	// input group outranks output group; each retire clears only its own bit
	task automatic t_endpoints;
		cyc(1);
		{iep_event_i, oep_event_i} <= {8'h08, 8'h02};
		cyc(1);
		{iep_event_i, oep_event_i} <= 16'h0000;
		cyc(5);
		#1;
		chk({14'h0, taken, offchip_irq_output_n_o}, 16'h0002);
		rd(4'h1, 8'h08);
		rd(4'h2, 8'h02);
		rd(4'h3, 8'h26);
		rd(4'h4, 8'h01);
		retire();
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h02);
		rd(4'h3, 8'h12);
		retire();
		rd(4'h2, 8'h00);
		rd(4'h3, 8'h00);
		chk({15'h0, combined_peripheral_request_n_o}, 16'h0001);
	endtask : t_endpoints
	// level slots 63 and 40: higher slot first, lower after a retire
	task automatic t_periph;
		cyc(1);
		periph_req_i <= 64'h8000_0100_0000_0000;
		cyc(3);
		rd(4'h3, 8'h7e);
		wr(4'h0, 8'h81);
		cyc(1);
		#1;
		chk(core_vector_addr_o, 16'h0003);
		retire();
		rd(4'h3, 8'h50);
		cyc(1);
		periph_req_i <= 64'h8000_0000_0000_0000;
		retire();
		// slot 63 still high but retired once, so it stays masked
		rd(4'h3, 8'h00);
		rd(4'h4, 8'h00);
		cyc(1);
		periph_req_i <= 64'h0;
		cyc(2);
		#1;
		chk({15'h0, combined_peripheral_request_n_o}, 16'h0001);
		chk({15'h0, core_irq_o}, 16'h0000);
	endtask : t_periph
	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// ceiling far above the hundred or so cycles the sequence needs
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		cyc(2);
		rst_n_i <= 1'b1;
		t_reset_values();
		t_core_sources();
		t_endpoints();
		t_periph();
		complete_run();
	end
endmodule : test_mia_top
